// ---- core/sbc_pkg.sv ----
// Package: register map, field layout, reset values and timing for the smart boost control block
package sbc_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] SBC_THRESH_OFS = 8'h60;
  localparam logic [7:0] SBC_MODE_OFS = 8'h61;
  localparam logic [7:0] SBC_MAXV_OFS = 8'h62;
  localparam logic [7:0] SBC_VBAT_OFS = 8'h6d;
  localparam logic [7:0] SBC_TEMP_OFS = 8'h6e;
  localparam logic [7:0] SBC_APPLIED_OFS = 8'h10;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int SBC_RTH_LSB = 8;
  localparam int SBC_ATH_LSB = 0;
  localparam int SBC_MODE_LSB = 4;
  localparam int SBC_TDEG_LSB = 0;
  localparam int SBC_VOUT_LSB = 0;
  localparam int SBC_LVL_W = 6;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [5:0] SBC_RTH_RST = 6'h04;
  localparam logic [5:0] SBC_ATH_RST = 6'h02;
  localparam logic [2:0] SBC_MODE_RST = 3'h2;
  localparam logic [2:0] SBC_TDEG_RST = 3'h6;
  localparam logic [3:0] SBC_VOUT_RST = 4'h8;
  localparam logic [9:0] SBC_VBAT_RST = 10'h263;
  localparam logic [9:0] SBC_TEMP_RST = 10'h019;
  localparam logic [3:0] SBC_RAIL_MIN = 4'h0;
  // ****************************************
  // Mode codes
  // ****************************************
  localparam logic [2:0] SBC_MODE_TRANSP = 3'h0;
  localparam logic [2:0] SBC_MODE_FORCE = 3'h1;
  localparam logic [2:0] SBC_MODE_SMART1 = 3'h5;
  localparam logic [2:0] SBC_MODE_SMART2 = 3'h6;
  // ****************************************
  // Timing: deglitch built from a 1.33 ms tick
  // ****************************************
  localparam int SBC_CLK_KHZ = 20000;
  localparam int SBC_TICK_US = 1330;
  localparam int SBC_TICK_CYC = SBC_CLK_KHZ * SBC_TICK_US / 1000;
  // Tick multiples per code: 1.33ms x1,2,4,16,64,256,1024,2048
  localparam logic [11:0] SBC_TDEG_TICKS [8] = '{12'h001, 12'h002, 12'h004, 12'h010,
                                                 12'h040, 12'h100, 12'h400, 12'h800};
  typedef enum logic [1:0] {
    SBC_ST_SUPPLY = 2'b00,
    SBC_ST_BOOST = 2'b01,
    SBC_ST_WAIT = 2'b11
  } sbc_state_t;
endpackage : sbc_pkg

// ---- core/sbc_tick.sv ----
// Divider that issues the one-cycle 1.33 ms deglitch tick
`timescale 1ns/100ps
module sbc_tick
  import sbc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  output logic tick_o
);
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  wire wrap = (cnt_r == 16'(SBC_TICK_CYC - 1));
  // ****************************************
  // Counter
  // ****************************************
  assign cnt_nxt = wrap ? 16'h0000 : cnt_r + 16'h0001;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= 16'h0000;
      tick_o <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_o <= wrap;
    end
  end
endmodule : sbc_tick

// ---- core/sbc_ctrl.sv ----
// Smart boost control: registers, level hysteresis, deglitch and rail selection
`timescale 1ns/100ps
// Function
// - Release level, below it rail returns to supply after deglitch
// - Attack level, above it rail is boosted
// - Mode field: transparent, forced, two smart
// - Deglitch code selects small-signal hold time
// - Max rail code limits converter, resets 8
// - Battery code read only, reset 0x263
// - Temperature code read only, reset 0x19
// - Applied rail code read-only status field
module sbc_ctrl
  import sbc_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic RESETN_I,
  input wire logic REG_WR_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [15:0] REG_WDATA_I,
  output logic [15:0] REG_RDATA_O,
  input wire logic [15:0] SAMPLE_MAG_I,
  input wire logic SAMPLE_VLD_I,
  input wire logic [9:0] VBAT_CODE_I,
  input wire logic [9:0] TEMP_CODE_I,
  input wire logic MEAS_VLD_I,
  output logic BOOST_EN_O,
  output logic [3:0] RAIL_CODE_O
);
  logic [5:0] rth_r;
  logic [5:0] ath_r;
  logic [2:0] mode_r;
  logic [2:0] tdeg_r;
  logic [3:0] vout_r;
  logic [9:0] vbat_r;
  logic [9:0] temp_r;
  logic [11:0] hold_r;
  logic [11:0] hold_nxt;
  logic boost_r;
  logic [3:0] rail_r;
  logic [3:0] rail_nxt;
  sbc_state_t st_r;
  sbc_state_t st_nxt;
  logic tick;

  // ****************************************
  // Register write decode
  // ****************************************
  wire wr_thr = REG_WR_I && (REG_ADDR_I == SBC_THRESH_OFS);
  wire wr_mode = REG_WR_I && (REG_ADDR_I == SBC_MODE_OFS);
  wire wr_maxv = REG_WR_I && (REG_ADDR_I == SBC_MAXV_OFS);

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rth_r <= SBC_RTH_RST;
      ath_r <= SBC_ATH_RST;
      mode_r <= SBC_MODE_RST;
      tdeg_r <= SBC_TDEG_RST;
      vout_r <= SBC_VOUT_RST;
    end else begin
      if (wr_thr) begin
        rth_r <= REG_WDATA_I[SBC_RTH_LSB +: SBC_LVL_W];
        ath_r <= REG_WDATA_I[SBC_ATH_LSB +: SBC_LVL_W];
      end
      if (wr_mode) begin
        mode_r <= REG_WDATA_I[SBC_MODE_LSB +: 3];
        tdeg_r <= REG_WDATA_I[SBC_TDEG_LSB +: 3];
      end
      if (wr_maxv) begin
        vout_r <= REG_WDATA_I[SBC_VOUT_LSB +: 4];
      end
    end
  end

  // ****************************************
  // Measurement capture from the sensors
  // ****************************************
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      vbat_r <= SBC_VBAT_RST;
      temp_r <= SBC_TEMP_RST;
    end else if (MEAS_VLD_I) begin
      vbat_r <= VBAT_CODE_I;
      temp_r <= TEMP_CODE_I;
    end
  end

  // ****************************************
  // Read mux, reserved bits zero
  // ****************************************
  wire [15:0] rd_thr = {2'b00, rth_r, 2'b00, ath_r};
  wire [15:0] rd_mode = {9'h000, mode_r, 1'b0, tdeg_r};
  assign REG_RDATA_O = (REG_ADDR_I == SBC_THRESH_OFS) ? rd_thr :
                       (REG_ADDR_I == SBC_MODE_OFS) ? rd_mode :
                       (REG_ADDR_I == SBC_MAXV_OFS) ? {12'h000, vout_r} :
                       (REG_ADDR_I == SBC_VBAT_OFS) ? {6'h00, vbat_r} :
                       (REG_ADDR_I == SBC_TEMP_OFS) ? {6'h00, temp_r} :
                       (REG_ADDR_I == SBC_APPLIED_OFS) ? {12'h000, rail_r} :
                       16'h0000;

  // ****************************************
  // Level compare on top six bits of magnitude
  // ****************************************
  wire [5:0] lvl = SAMPLE_MAG_I[15 -: SBC_LVL_W];
  wire smart = (mode_r == SBC_MODE_SMART1) || (mode_r == SBC_MODE_SMART2);
  wire above_att = SAMPLE_VLD_I && (lvl > ath_r);
  wire below_rel = SAMPLE_VLD_I && (lvl < rth_r);
  wire not_small = SAMPLE_VLD_I && !below_rel;
  wire hold_done = (hold_r >= SBC_TDEG_TICKS[tdeg_r]);

  sbc_tick u_tick (
    .clk_i(CLOCK_I),
    .rst_n_i(RESETN_I),
    .tick_o(tick)
  );

  // ****************************************
  // Hysteresis state machine
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    hold_nxt = hold_r;
    case (st_r)
      SBC_ST_SUPPLY: begin
        if (above_att) begin
          st_nxt = SBC_ST_BOOST;
        end
      end
      SBC_ST_BOOST: begin
        hold_nxt = 12'h000;
        if (below_rel) begin
          st_nxt = SBC_ST_WAIT;
        end
      end
      SBC_ST_WAIT: begin
        if (not_small) begin
          st_nxt = SBC_ST_BOOST;
        end else if (hold_done) begin
          st_nxt = SBC_ST_SUPPLY;
        end else if (tick) begin
          hold_nxt = hold_r + 12'h001;
        end
      end
      default: begin
        st_nxt = SBC_ST_SUPPLY;
      end
    endcase
  end

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      st_r <= SBC_ST_SUPPLY;
      hold_r <= 12'h000;
    end else if (!smart) begin
      st_r <= SBC_ST_SUPPLY;
      hold_r <= 12'h000;
    end else begin
      st_r <= st_nxt;
      hold_r <= hold_nxt;
    end
  end

  // ****************************************
  // Rail selection per mode
  // ****************************************
  wire boost_nxt = (mode_r == SBC_MODE_FORCE) ||
                   (smart && (st_nxt != SBC_ST_SUPPLY));
  assign rail_nxt = boost_nxt ? vout_r : SBC_RAIL_MIN;

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      boost_r <= 1'b0;
      rail_r <= SBC_RAIL_MIN;
    end else begin
      boost_r <= boost_nxt;
      rail_r <= rail_nxt;
    end
  end

  assign BOOST_EN_O = boost_r;
  assign RAIL_CODE_O = rail_r;

  // ****************************************
  // Assertions
  // ****************************************
  property p_rel_no_boost;
    @(posedge CLOCK_I) disable iff (!RESETN_I)
    (smart && st_r == SBC_ST_SUPPLY && !above_att && !wr_mode && $stable(mode_r)) |=> !boost_r;
  endproperty
  a_rel_no_boost: assert property (p_rel_no_boost) else $error("boost raised without attack");

  property p_attack;
    @(posedge CLOCK_I) disable iff (!RESETN_I)
    (smart && above_att && !wr_mode) |=> boost_r;
  endproperty
  a_attack: assert property (p_attack) else $error("attack did not raise rail");

  property p_force;
    @(posedge CLOCK_I) disable iff (!RESETN_I)
    (mode_r == SBC_MODE_FORCE && !wr_mode) |=> (boost_r && rail_r == $past(vout_r));
  endproperty
  a_force: assert property (p_force) else $error("forced boost not applied");

  property p_transp;
    @(posedge CLOCK_I) disable iff (!RESETN_I)
    (mode_r == SBC_MODE_TRANSP && !wr_mode) |=> !boost_r;
  endproperty
  a_transp: assert property (p_transp) else $error("transparent mode boosted");

  property p_wait_hold;
    @(posedge CLOCK_I) disable iff (!RESETN_I)
    (st_r == SBC_ST_WAIT && !hold_done && smart && !wr_mode) |=> boost_r;
  endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("rail lowered before deglitch");

  property p_max_rail;
    @(posedge CLOCK_I) disable iff (!RESETN_I)
    boost_r |-> (rail_r == $past(vout_r));
  endproperty
  a_max_rail: assert property (p_max_rail) else $error("applied rail differs from max code");

  property p_vbat;
    @(posedge CLOCK_I) disable iff (!RESETN_I)
    MEAS_VLD_I |=> (REG_ADDR_I != SBC_VBAT_OFS || REG_RDATA_O[9:0] == $past(VBAT_CODE_I));
  endproperty
  a_vbat: assert property (p_vbat) else $error("battery code not shown");

  property p_temp;
    @(posedge CLOCK_I) disable iff (!RESETN_I)
    MEAS_VLD_I |=> (temp_r == $past(TEMP_CODE_I));
  endproperty
  a_temp: assert property (p_temp) else $error("temperature code not captured");

  property p_status;
    @(posedge CLOCK_I) disable iff (!RESETN_I)
    (REG_ADDR_I == SBC_APPLIED_OFS) |-> (REG_RDATA_O == {12'h000, (boost_r ? $past(vout_r) : SBC_RAIL_MIN)});
  endproperty
  a_status: assert property (p_status) else $error("status rail mismatch");

  sequence s_small;
    smart && st_r == SBC_ST_BOOST && below_rel && !wr_mode;
  endsequence
  property p_hyst;
    @(posedge CLOCK_I) disable iff (!RESETN_I)
    s_small |=> (st_r == SBC_ST_WAIT && boost_r);
  endproperty
  a_hyst: assert property (p_hyst) else $error("small signal did not start deglitch");
endmodule : sbc_ctrl

// ---- verif/sbc_sense_model.sv ----
// Behavioural model of the battery and temperature sensors feeding the monitor codes
`timescale 1ns/100ps
module sbc_sense_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  output logic meas_vld_o,
  output logic [9:0] vbat_code_o,
  output logic [9:0] temp_code_o,
  output logic [9:0] last_vbat_o,
  output logic [9:0] last_temp_o
);
  integer seed = 32'h271ec643;
  logic [5:0] cnt_r;
  // ****************************************
  // Conversion every 64 cycles, codes invalid in between
  // ****************************************
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= 6'h00;
      meas_vld_o <= 1'b0;
      vbat_code_o <= 10'h155;
      temp_code_o <= 10'h2aa;
      last_vbat_o <= 10'h263;
      last_temp_o <= 10'h019;
    end else begin
      cnt_r <= cnt_r + 6'h01;
      // Remember what the monitor should now show
      if (meas_vld_o) begin
        last_vbat_o <= vbat_code_o;
        last_temp_o <= temp_code_o;
      end
      meas_vld_o <= (cnt_r == 6'h3f);
      if (cnt_r == 6'h3f) begin
        vbat_code_o <= 10'($random(seed));
        temp_code_o <= 10'($random(seed));
      end else begin
        vbat_code_o <= ~vbat_code_o;
        temp_code_o <= ~temp_code_o;
      end
    end
  end
endmodule : sbc_sense_model

// ---- verif/tb.sv ----
// Self-checking testbench for the smart boost control block
`timescale 1ns/100ps
module tb;
  import sbc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr = 1'b0;
  logic vld = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] mag = 16'h0000;
  logic [15:0] rdata;
  logic boost_en;
  logic [3:0] rail;
  logic meas_vld;
  logic [9:0] vbat, temp, last_vbat, last_temp;
  logic [15:0] d;
  logic [15:0] msk [3] = '{16'h3f3f, 16'h0077, 16'h000f};
  integer seed = 32'h271ec643;
  integer n_fail = 0;
  integer n_compared = 0;
  integer vout, i, k;
  always #25 clk = ~clk;
  sbc_ctrl i_sbc_ctrl (.CLOCK_I(clk), .RESETN_I(rst_n), .REG_WR_I(wr), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
    .REG_RDATA_O(rdata), .SAMPLE_MAG_I(mag), .SAMPLE_VLD_I(vld), .VBAT_CODE_I(vbat), .TEMP_CODE_I(temp),
    .MEAS_VLD_I(meas_vld), .BOOST_EN_O(boost_en), .RAIL_CODE_O(rail));
  sbc_sense_model i_sbc_sense_model (.clk_i(clk), .rst_n_i(rst_n), .meas_vld_o(meas_vld), .vbat_code_o(vbat),
    .temp_code_o(temp), .last_vbat_o(last_vbat), .last_temp_o(last_temp));
  // ****************************************
  // Bus, sample and compare tasks
  // ****************************************
  task give_verdict;
    if (n_fail == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict
  task rd_chk(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    #1 addr = a;
    #1 n_compared++;
    if (rdata !== e) begin
      n_fail++;
      $display("[ERR] reg %h exp %h seen %h", a, e, rdata);
    end
  endtask : rd_chk
  task chk_out(input logic e_en, input logic [3:0] e_rail);
    n_compared++;
    if (boost_en !== e_en || rail !== e_rail) begin
      n_fail++;
      $display("[ERR] boost/rail exp %b/%h seen %b/%h", e_en, e_rail, boost_en, rail);
    end
  endtask : chk_out
  task wr_reg(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    #1 wr = 1'b1;
    addr = a;
    wdata = v;
    @(posedge clk);
    #1 wr = 1'b0;
    wdata = 16'($random(seed));
  endtask : wr_reg
  task send(input logic [5:0] lvl);
    @(posedge clk);
    #1 vld = 1'b1;
    mag = {lvl, 10'($random(seed))};
    @(posedge clk);
    #1 vld = 1'b0;
    mag = 16'($random(seed));
  endtask : send
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    rd_chk(8'h60, 16'h0402);
    rd_chk(8'h61, 16'h0026);
    rd_chk(8'h62, 16'h0008);
    rd_chk(8'h6d, 16'h0263);
    rd_chk(8'h6e, 16'h0019);
    rd_chk(8'h10, 16'h0000);
    rd_chk(8'h00, 16'h0000);
    chk_out(1'b0, 4'h0);
    // Hysteresis: attack 10, release 4, shortest deglitch
    vout = 1 + {$random(seed)} % 15;
    wr_reg(8'h62, 16'(vout));
    wr_reg(8'h60, 16'h040a);
    wr_reg(8'h61, 16'h0050);
    send(6'd10);
    chk_out(1'b0, 4'h0);
    send(6'd11);
    chk_out(1'b1, 4'(vout));
    rd_chk(8'h10, 16'(vout));
    send(6'd5);
    send(6'd4);
    chk_out(1'b1, 4'(vout));
    send(6'd3);
    chk_out(1'b1, 4'(vout));
    // A non-small sample restarts the deglitch wait
    send(6'd4);
    send(6'd3);
    chk_out(1'b1, 4'(vout));
    k = 0;
    while (boost_en !== 1'b0 && k < SBC_TICK_CYC * SBC_TDEG_TICKS[0] + 4) begin
      @(posedge clk);
      #1 k++;
    end
    chk_out(1'b0, 4'h0);
    rd_chk(8'h10, 16'h0000);
    // Every mode code with a loud sample
    for (i = 0; i < 8; i++) begin
      wr_reg(8'h61, 16'(i << 4));
      send(6'd63);
      chk_out(i == 1 || i == 5 || i == 6, (i == 1 || i == 5 || i == 6) ? 4'(vout) : 4'h0);
    end
    // Field widths and reserved bits
    for (i = 0; i < 3; i++) begin
      d = 16'($random(seed));
      wr_reg(8'(8'h60 + i), d);
      rd_chk(8'(8'h60 + i), d & msk[i]);
    end
    // Monitors follow the sensors; battery code ignores writes
    for (i = 0; i < 3; i++) begin
      wr_reg(8'h6d, 16'hffff);
      rd_chk(8'h6e, {6'h00, last_temp});
      rd_chk(8'h6d, {6'h00, last_vbat});
      // Address left on the battery code across a capture
      repeat (70) @(posedge clk);
    end
    // Forced boost, then a reset in mid-run
    wr_reg(8'h61, 16'h0010);
    @(posedge clk);
    #1 chk_out(1'b1, d[3:0]);
    @(posedge clk);
    #1 rst_n = 1'b0;
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    chk_out(1'b0, 4'h0);
    rd_chk(8'h62, 16'h0008);
    rd_chk(8'h6d, {6'h00, last_vbat});
    chk_out(1'b0, 4'h0);
    give_verdict;
  end
  // Watchdog against a hang
  initial begin
    #(60000 * 50);
    n_fail++;
    give_verdict;
  end
endmodule : tb
